// ---- common/plf_pkg.sv ----
// Shared constants and types for the pointer-load / file-copy execute block
package plf_pkg;
   // Instruction encodings
   localparam logic [9:0]  PLL_W1_PFX     = 10'h3B8;   // 1110 1110 00
   localparam logic [7:0]  PLL_W2_PFX     = 8'hF0;     // 1111 0000
   localparam logic [5:0]  FCP_PFX        = 6'h14;     // 0101 00
   localparam logic [7:0]  BSL_PFX        = 8'h01;     // 0000 0001
   localparam int          PTR_W          = 12;
   localparam int          PTR_NUM        = 3;
   localparam logic [1:0]  PTR_IDX_NONE   = 2'h3;
   localparam logic [7:0]  ACCESS_SPLIT   = 8'h80;
   localparam logic [3:0]  ACCESS_LO_BANK = 4'h0;
   localparam logic [3:0]  ACCESS_HI_BANK = 4'hF;
   // Register offsets (byte addresses)
   localparam int          ADR_W          = 8;
   localparam logic [7:0]  REG_CTRL       = 8'h00;
   localparam logic [7:0]  REG_STATUS     = 8'h04;
   localparam logic [7:0]  REG_WACC       = 8'h08;
   localparam logic [7:0]  REG_BANK_SEL   = 8'h0C;
   localparam logic [7:0]  REG_PTR0       = 8'h10;
   localparam logic [7:0]  REG_PTR1       = 8'h14;
   localparam logic [7:0]  REG_PTR2       = 8'h18;
   // Field positions
   localparam int          CTRL_RUN_BIT   = 0;
   localparam int          ST_Z_BIT       = 0;
   localparam int          ST_N_BIT       = 1;
   localparam int          ST_PEND_BIT    = 2;
   // Reset values
   localparam logic        RST_RUN        = 1'b0;
   localparam logic [7:0]  RST_WACC       = 8'h00;
   localparam logic [7:0]  RST_BANK_SEL   = 8'h00;
   localparam logic [11:0] RST_PTR        = 12'h000;
   localparam logic [1:0]  PH_LAST        = 2'h3;

   typedef enum logic [1:0] {
      OP_NONE = 2'b00,
      OP_PLL  = 2'b01,
      OP_FCP  = 2'b10,
      OP_BSL  = 2'b11
   } plf_op_t;

   typedef enum logic [1:0] {
      PH_Q1 = 2'b00,
      PH_Q2 = 2'b01,
      PH_Q3 = 2'b10,
      PH_Q4 = 2'b11
   } plf_phase_t;

   typedef enum logic {
      SEQ_FIRST  = 1'b0,
      SEQ_SECOND = 1'b1
   } plf_seq_t;
endpackage : plf_pkg

// ---- common/plf_dec_if.sv ----
// Decoded instruction fields passed from decoder to execute logic
`timescale 1ns/10ps
interface plf_dec_if;
   import plf_pkg::*;
   logic [15:0] word;
   plf_op_t     op;
   logic [1:0]  ptr_idx;
   logic [3:0]  lit_hi;
   logic [7:0]  lit_lo;
   logic        second_ok;
   logic        dest;
   logic        bank_mode;
   logic [7:0]  faddr;
   modport dec (input word, output op, ptr_idx, lit_hi, lit_lo, second_ok, dest, bank_mode,
                faddr);
   modport exe (output word, input op, ptr_idx, lit_hi, lit_lo, second_ok, dest, bank_mode,
                faddr);
endinterface : plf_dec_if

// ---- hdl/plf_phase_gen.sv ----
// Four-phase instruction cycle generator, one-cycle enable per phase
`timescale 1ns/10ps
module plf_phase_gen
   import plf_pkg::*;
(
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       run_i,
   output plf_phase_t      phase_o,
   output logic            step_o
);
   plf_phase_t phase;
   plf_phase_t next_phase;

   always_comb begin
      next_phase = phase;
      if (run_i) begin
         next_phase = plf_phase_t'(phase + 2'h1);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         phase <= PH_Q1;
      end else begin
         phase <= next_phase;
      end
   end

   assign phase_o = phase;
   assign step_o  = run_i;
endmodule : plf_phase_gen

// ---- hdl/plf_decoder.sv ----
// Combinational opcode decoder for the supported instructions
`timescale 1ns/10ps
module plf_decoder
   import plf_pkg::*;
(
   plf_dec_if.dec d
);
   always_comb begin
      d.op = OP_NONE;
      if (d.word[15:6] == PLL_W1_PFX) begin
         d.op = OP_PLL;
      end else if (d.word[15:10] == FCP_PFX) begin
         d.op = OP_FCP;
      end else if (d.word[15:8] == BSL_PFX) begin
         d.op = OP_BSL;
      end
   end

   assign d.ptr_idx   = d.word[5:4];
   assign d.lit_hi    = d.word[3:0];
   assign d.lit_lo    = d.word[7:0];
   assign d.second_ok = (d.word[15:8] == PLL_W2_PFX);
   assign d.dest      = d.word[9];
   assign d.bank_mode = d.word[8];
   assign d.faddr     = d.word[7:0];
endmodule : plf_decoder

// ---- hdl/plf_core.sv ----
// Pointer-literal-load and file-copy execute block with Wishbone registers
`timescale 1ns/10ps
module plf_core
   import plf_pkg::*;
#(
   parameter logic [7:0] ACC_SPLIT = ACCESS_SPLIT
)
(
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   // Wishbone classic slave
   input  wire logic             cyc_i,
   input  wire logic             stb_i,
   input  wire logic             we_i,
   input  wire logic [ADR_W-1:0] adr_i,
   input  wire logic [3:0]       sel_i,
   input  wire logic [31:0]      dat_i,
   output logic [31:0]           dat_o,
   output logic                  ack_o,
   // Instruction fetch path
   input  wire logic             instr_valid_i,
   input  wire logic [15:0]      instr_i,
   output logic                  instr_ack_o,
   // Data memory
   output logic [11:0]           dm_addr_o,
   output logic                  dm_re_o,
   input  wire logic [7:0]       dm_rdata_i,
   output logic                  dm_we_o,
   output logic [7:0]            dm_wdata_o
);
   ////////////////////////////////////////////////////////////////////////////
   // Phase generator and decoder
   plf_phase_t phase;
   logic       step;
   logic       run;
   plf_dec_if  dif ();

   plf_phase_gen u_phase (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .run_i   (run),
      .phase_o (phase),
      .step_o  (step)
   );

   plf_decoder u_dec (
      .d (dif)
   );

   logic q1;
   logic q2;
   logic q3;
   logic q4;
   assign q1 = step && (phase == PH_Q1);
   assign q2 = step && (phase == PH_Q2);
   assign q3 = step && (phase == PH_Q3);
   assign q4 = step && (phase == PH_Q4);

   ////////////////////////////////////////////////////////////////////////////
   // Core state
   logic [15:0]      ir;
   logic             ir_valid;
   plf_seq_t         seq;
   logic [1:0]       pend_idx;
   logic [7:0]       mv;
   logic [7:0]       wacc;
   logic [7:0]       bank_sel;
   logic             flag_z;
   logic             flag_n;
   logic [PTR_W-1:0] ptr      [PTR_NUM];
   logic             ack_q;

   logic [15:0]      next_ir;
   logic             next_ir_valid;
   plf_seq_t         next_seq;
   logic [1:0]       next_pend_idx;
   logic [7:0]       next_mv;
   logic [7:0]       next_wacc;
   logic [7:0]       next_bank_sel;
   logic             next_flag_z;
   logic             next_flag_n;
   logic [PTR_W-1:0] next_ptr [PTR_NUM];
   logic             next_run;
   logic             next_ack;
   logic [31:0]      next_dat;
   logic [11:0]      next_dm_addr;
   logic             next_dm_re;
   logic             next_dm_we;
   logic [7:0]       next_dm_wdata;
   logic             next_instr_ack;

   assign dif.word = ir;

   logic        wb_req;
   logic        wb_wr;
   logic [11:0] bank_addr;
   logic        fcp_now;
   logic        pll_now;

   assign wb_req  = cyc_i && stb_i && !ack_q;
   assign wb_wr   = wb_req && we_i;
   // Second word is never decoded as a new opcode
   assign fcp_now = ir_valid && (seq == SEQ_FIRST) && (dif.op == OP_FCP);
   assign pll_now = ir_valid && (seq == SEQ_FIRST) && (dif.op == OP_PLL);

   // Access bank splits low RAM and high special registers
   always_comb begin
      if (dif.bank_mode) begin
         bank_addr = {bank_sel[3:0], dif.faddr};
      end else if (dif.faddr < ACC_SPLIT) begin
         bank_addr = {ACCESS_LO_BANK, dif.faddr};
      end else begin
         bank_addr = {ACCESS_HI_BANK, dif.faddr};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Next-state logic: software writes first, instruction writes override
   always_comb begin
      next_ir        = ir;
      next_ir_valid  = ir_valid;
      next_seq       = seq;
      next_pend_idx  = pend_idx;
      next_mv        = mv;
      next_wacc      = wacc;
      next_bank_sel  = bank_sel;
      next_flag_z    = flag_z;
      next_flag_n    = flag_n;
      next_ptr       = ptr;
      next_run       = run;

      // Software writes first; an instruction write in the same cycle wins
      if (wb_wr && sel_i[0]) begin
         unique case (adr_i)
            REG_CTRL: next_run = dat_i[CTRL_RUN_BIT];
            REG_WACC: next_wacc = dat_i[7:0];
            REG_BANK_SEL: next_bank_sel = dat_i[7:0];
            REG_PTR0: next_ptr[0][7:0] = dat_i[7:0];
            REG_PTR1: next_ptr[1][7:0] = dat_i[7:0];
            REG_PTR2: next_ptr[2][7:0] = dat_i[7:0];
            default:  next_run = run;
         endcase
      end
      if (wb_wr && sel_i[1]) begin
         unique case (adr_i)
            REG_PTR0: next_ptr[0][11:8] = dat_i[11:8];
            REG_PTR1: next_ptr[1][11:8] = dat_i[11:8];
            REG_PTR2: next_ptr[2][11:8] = dat_i[11:8];
            default:  next_run = next_run;
         endcase
      end

      // Q1: take next program word; no word means an idle cycle
      if (q1) begin
         next_ir_valid = instr_valid_i;
         if (instr_valid_i) begin
            next_ir = instr_i;
         end
      end

      // Q3: process data
      if (q3 && fcp_now) begin
         next_mv = dm_rdata_i;
      end

      // Q4: write results
      if (q4) begin
         if (seq == SEQ_SECOND) begin
            // Missing or malformed second word aborts the low-byte write
            if (ir_valid && dif.second_ok && pend_idx != PTR_IDX_NONE) begin
               next_ptr[pend_idx][7:0] = dif.lit_lo;
            end
            next_seq = SEQ_FIRST;
         end else if (pll_now) begin
            if (dif.ptr_idx != PTR_IDX_NONE) begin
               next_ptr[dif.ptr_idx][11:8] = dif.lit_hi;
            end
            next_pend_idx = dif.ptr_idx;
            next_seq      = SEQ_SECOND;
         end else if (fcp_now) begin
            if (!dif.dest) begin
               next_wacc = mv;
            end
            next_flag_z = (mv == 8'h00);
            next_flag_n = mv[7];
         end else if (ir_valid && dif.op == OP_BSL) begin
            next_bank_sel = dif.lit_lo;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Bus response: read data stands only in the acknowledge cycle
   always_comb begin
      next_ack = wb_req;
      next_dat = 32'h0000_0000;
      // Unmapped offsets read as zero
      if (wb_req && !we_i) begin
         unique case (adr_i)
            REG_CTRL:     next_dat[CTRL_RUN_BIT] = run;
            REG_STATUS:   next_dat[2:0] = {seq == SEQ_SECOND, flag_n, flag_z};
            REG_WACC:     next_dat[7:0] = wacc;
            REG_BANK_SEL: next_dat[7:0] = bank_sel;
            REG_PTR0:     next_dat[11:0] = ptr[0];
            REG_PTR1:     next_dat[11:0] = ptr[1];
            REG_PTR2:     next_dat[11:0] = ptr[2];
            default:      next_dat = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
         dat_o <= 32'h0000_0000;
      end else begin
         ack_q <= next_ack;
         dat_o <= next_dat;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Fetch and data-memory strobes, registered so the far side sees clean pulses
   always_comb begin
      next_instr_ack = q1 && instr_valid_i;
      next_dm_addr   = dm_addr_o;
      next_dm_re     = 1'b0;
      next_dm_we     = 1'b0;
      next_dm_wdata  = dm_wdata_o;

      // Q2: read the file register
      if (q2 && fcp_now) begin
         next_dm_addr = bank_addr;
         next_dm_re   = 1'b1;
      end
      // Address from Q2 still stands, so write-back hits the source register
      if (q4 && fcp_now && dif.dest) begin
         next_dm_we    = 1'b1;
         next_dm_wdata = mv;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         instr_ack_o <= 1'b0;
         dm_addr_o   <= 12'h000;
         dm_re_o     <= 1'b0;
         dm_we_o     <= 1'b0;
         dm_wdata_o  <= 8'h00;
      end else begin
         instr_ack_o <= next_instr_ack;
         dm_addr_o   <= next_dm_addr;
         dm_re_o     <= next_dm_re;
         dm_we_o     <= next_dm_we;
         dm_wdata_o  <= next_dm_wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ir          <= 16'h0000;
         ir_valid    <= 1'b0;
         seq         <= SEQ_FIRST;
         pend_idx    <= PTR_IDX_NONE;
         mv          <= 8'h00;
         wacc        <= RST_WACC;
         bank_sel    <= RST_BANK_SEL;
         flag_z      <= 1'b0;
         flag_n      <= 1'b0;
         for (int i = 0; i < PTR_NUM; i++) begin
            ptr[i] <= RST_PTR;
         end
         run         <= RST_RUN;
      end else begin
         ir          <= next_ir;
         ir_valid    <= next_ir_valid;
         seq         <= next_seq;
         pend_idx    <= next_pend_idx;
         mv          <= next_mv;
         wacc        <= next_wacc;
         bank_sel    <= next_bank_sel;
         flag_z      <= next_flag_z;
         flag_n      <= next_flag_n;
         ptr         <= next_ptr;
         run         <= next_run;
      end
   end

   assign ack_o = ack_q;
endmodule : plf_core

// ---- tb/plf_fetch_mem.sv ----
// Behavioural program-word source and data memory facing the block
`timescale 1ns/10ps
module plf_fetch_mem (
   input  wire logic        clk_i,
   input  wire logic        instr_ack_i,
   output logic             instr_valid_o,
   output logic [15:0]      instr_o,
   input  wire logic [11:0] dm_addr_i,
   input  wire logic        dm_re_i,
   input  wire logic        dm_we_i,
   input  wire logic [7:0]  dm_wdata_i,
   output logic [7:0]       dm_rdata_o
);
   logic [7:0] mem [4096];
   logic [7:0] last_rd = 8'h00;
   int         wr_count = 0;
   initial begin
      instr_valid_o = 1'b0;
      instr_o = 16'h0000;
   end
   // Data only while read is requested, else the inverse of the last read value
   assign dm_rdata_o = dm_re_i ? mem[dm_addr_i] : ~last_rd;
   always @(posedge clk_i) begin
      if (dm_re_i) last_rd <= mem[dm_addr_i];
      if (dm_we_i) begin
         mem[dm_addr_i] <= dm_wdata_i;
         wr_count <= wr_count + 1;
      end
   end
   // Word held until acknowledged; a gap cycle before the next offer
   task automatic issue(input logic [15:0] w);
      instr_valid_o <= 1'b1;
      instr_o <= w;
      do @(posedge clk_i); while (instr_ack_i !== 1'b1);
      instr_valid_o <= 1'b0;
      instr_o <= ~w;
      @(posedge clk_i);
   endtask : issue
endmodule : plf_fetch_mem

// ---- tb/plf_core_sva.sv ----
// Port-level assertion checker for the execute block
`timescale 1ns/10ps
module plf_core_chk
   import plf_pkg::*;
#(
   parameter logic [7:0] ACC_SPLIT = ACCESS_SPLIT
)
(
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        cyc_i,
   input wire logic        stb_i,
   input wire logic [31:0] dat_o,
   input wire logic        ack_o,
   input wire logic [15:0] instr_i,
   input wire logic        instr_ack_o,
   input wire logic [11:0] dm_addr_o,
   input wire logic        dm_re_o,
   input wire logic [7:0]  dm_rdata_i,
   input wire logic        dm_we_o,
   input wire logic [7:0]  dm_wdata_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic [11:0] acc_addr;
   always_comb begin
      acc_addr = (instr_i[7:0] < ACC_SPLIT) ? {ACCESS_LO_BANK, instr_i[7:0]}
                                            : {ACCESS_HI_BANK, instr_i[7:0]};
   end
   property p_ack_once;   cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o;  endproperty
   property p_ack_cause;  ack_o |-> $past(cyc_i && stb_i);                endproperty
   property p_dat_quiet;  !ack_o |-> dat_o == 32'h0;                      endproperty
   property p_iack_gap;   instr_ack_o |=> !instr_ack_o [*3];              endproperty
   property p_read_slot;
      dm_re_o |-> $past(instr_ack_o) && $past(instr_i[15:10]) == FCP_PFX;
   endproperty
   property p_bank_sel;
      instr_ack_o && instr_i[15:10] == FCP_PFX && !instr_i[8]
         |=> dm_re_o && dm_addr_o == $past(acc_addr);
   endproperty
   property p_write_slot; dm_we_o |-> $past(dm_re_o, 2) && $stable(dm_addr_o); endproperty
   property p_write_data; dm_we_o |-> dm_wdata_o == $past(dm_rdata_i, 2);      endproperty
   property p_write_dest; dm_we_o |-> $past(instr_i[9], 3);                     endproperty
   a_ack_once:   assert property (p_ack_once)   else $error("ack not a single pulse");
   a_ack_cause:  assert property (p_ack_cause)  else $error("ack without request");
   a_dat_quiet:  assert property (p_dat_quiet)  else $error("read data outside ack");
   a_iack_gap:   assert property (p_iack_gap)   else $error("words closer than 4 clocks");
   a_read_slot:  assert property (p_read_slot)  else $error("read not after copy decode");
   a_bank_sel:   assert property (p_bank_sel)   else $error("access bank address wrong");
   a_write_slot: assert property (p_write_slot) else $error("write not 2 after read");
   a_write_data: assert property (p_write_data) else $error("write data not read value");
   a_write_dest: assert property (p_write_dest) else $error("file write with dest 0");
   c_pll:  cover property (instr_ack_o && instr_i[15:6] == PLL_W1_PFX);
   c_wrbk: cover property (dm_we_o);
   c_bus:  cover property (ack_o);
endmodule : plf_core_chk
bind plf_core plf_core_chk #(.ACC_SPLIT(ACC_SPLIT)) u_chk (.clk_i, .rst_i, .cyc_i, .stb_i,
   .dat_o, .ack_o, .instr_i, .instr_ack_o, .dm_addr_o, .dm_re_o, .dm_rdata_i, .dm_we_o,
   .dm_wdata_o);

// ---- tb/plf_core_bench.sv ----
// Self-checking bench for the pointer-load / file-copy block
`timescale 1ns/10ps
module plf_core_bench;
   import plf_pkg::*;
   logic        clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
   logic [7:0]  adr_i = 8'h00;
   logic [3:0]  sel_i = 4'h0;
   logic [31:0] dat_i = 32'h0, dat_o, rd;
   logic        ack_o, instr_valid_i, instr_ack_o, dm_re_o, dm_we_o;
   logic [15:0] instr_i;
   logic [11:0] dm_addr_o;
   logic [7:0]  dm_rdata_i, dm_wdata_o;
   int          failures = 0, check_count = 0, cycles = 0, n;
   logic [11:0] lit [3] = '{12'h3AB, 12'hC54, 12'hFFF};
   logic [7:0]  regs [8] = '{REG_CTRL, REG_STATUS, REG_WACC, REG_BANK_SEL, REG_PTR0, REG_PTR1,
                             REG_PTR2, 8'hFC};
   always #12.5 clk_i = ~clk_i;
   plf_core dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
      .ack_o, .instr_valid_i, .instr_i, .instr_ack_o, .dm_addr_o, .dm_re_o, .dm_rdata_i,
      .dm_we_o, .dm_wdata_o);
   plf_fetch_mem fm (.clk_i, .instr_ack_i(instr_ack_o), .instr_valid_o(instr_valid_i),
      .instr_o(instr_i), .dm_addr_i(dm_addr_o), .dm_re_i(dm_re_o), .dm_we_i(dm_we_o),
      .dm_wdata_i(dm_wdata_o), .dm_rdata_o(dm_rdata_i));
   ////////////////////////////////////////////////////////////////////////////////
   task conclude;
      $display("failures=%0d check_count=%0d", failures, check_count);
      if (failures == 0 && check_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : conclude
   task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= d;
      sel_i <= 4'hF;
      do @(posedge clk_i); while (ack_o !== 1'b1);
      rd = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      @(posedge clk_i);
   endtask : wb
   task rdchk(input logic [7:0] a, input logic [31:0] e, input string s);
      wb(1'b0, a, 32'h0);
      chk(rd, e, s);
   endtask : rdchk
   // Q4 of the last word lands within three clocks of the issue return
   task exec(input logic [15:0] w);
      fm.issue(w);
      repeat (3) @(posedge clk_i);
   endtask : exec
   task pload(input logic [1:0] i, input logic [11:0] k);
      fm.issue({8'hEE, 2'b00, i, k[11:8]});
      exec({8'hF0, k[7:0]});
   endtask : pload
   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 4000) begin
         failures++;
         conclude();
      end
   end
   initial begin
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      foreach (regs[i]) rdchk(regs[i], 32'h0, "reset value");
      wb(1'b1, REG_WACC, 32'h5A);
      rdchk(REG_WACC, 32'h5A, "accumulator rw");
      wb(1'b1, 8'hFC, 32'hFF);
      rdchk(8'hFC, 32'h0, "unmapped read");
      fm.mem[12'h005] = 8'h00;
      fm.mem[12'hF90] = 8'h80;
      fm.mem[12'h2AB] = 8'h22;
      wb(1'b1, REG_CTRL, 32'h1);
      exec(16'h5005);
      rdchk(REG_WACC, 32'h00, "copy low access");
      rdchk(REG_STATUS, 32'h1, "zero flag");
      exec(16'h5090);
      rdchk(REG_WACC, 32'h80, "copy high access");
      rdchk(REG_STATUS, 32'h2, "negative flag");
      exec(16'h0102);
      rdchk(REG_BANK_SEL, 32'h2, "bank literal load");
      exec(16'h51AB);
      rdchk(REG_WACC, 32'h22, "copy via bank select");
      rdchk(REG_STATUS, 32'h0, "flags cleared");
      n = fm.wr_count;
      exec(16'h5290);
      rdchk(REG_WACC, 32'h22, "dest 1 keeps acc");
      chk(fm.wr_count, n + 1, "one write back");
      chk({24'h0, fm.mem[12'hF90]}, 32'h80, "write back value");
      foreach (lit[i]) pload(i[1:0], lit[i]);
      foreach (lit[i]) rdchk(REG_PTR0 + 8'(4 * i), {20'h0, lit[i]}, "pointer load");
      rdchk(REG_STATUS, 32'h2, "flags kept by load");
      pload(2'h3, 12'h123);
      foreach (lit[i]) rdchk(REG_PTR0 + 8'(4 * i), {20'h0, lit[i]}, "index 3 inert");
      fm.issue(16'hEE05);
      exec(16'h1234);
      rdchk(REG_PTR0, 32'h5AB, "bad second word");
      conclude();
   end
endmodule : plf_core_bench
